// ==== verilog/pmc_pkg.sv ====
package pmc_pkg;

  // Command codes of the bank
  localparam logic [7:0] PMC_CMD_INPUT_OFFSET_TRIMS   = 8'hdd;
  localparam logic [7:0] PMC_CMD_OUTPUT_TRIM_MONITOR  = 8'hde;
  localparam logic [7:0] PMC_CMD_STARTUP_STATUS_HIST  = 8'hdf;
  localparam logic [7:0] PMC_CMD_FEATURE_OPTION_BYTE  = 8'he0;
  localparam logic [7:0] PMC_CMD_INTERNAL_TEMP_OFFSET = 8'he1;
  localparam logic [7:0] PMC_CMD_EXT_TEMP_CALIBRATION = 8'he2;

  // Answer lengths in bytes
  localparam logic [5:0] PMC_LEN_NONE  = 6'h00;
  localparam logic [5:0] PMC_LEN_BYTE  = 6'h01;
  localparam logic [5:0] PMC_LEN_WORD  = 6'h02;
  localparam logic [5:0] PMC_LEN_BLK4  = 6'h04;
  localparam logic [5:0] PMC_LEN_BLK32 = 6'h20;

  // Feature option byte fields
  localparam int PMC_OPT_PEC_BIT    = 7;
  localparam int PMC_OPT_HRR_BIT    = 6;
  localparam int PMC_OPT_DROOP_BIT  = 5;
  localparam int PMC_OPT_ART_BIT    = 3;
  localparam int PMC_OPT_DBV_BIT    = 2;
  localparam logic [7:0] PMC_OPT_RESET = 8'h00;

  // History timing
  localparam int unsigned PMC_CLK_HZ        = 40_000_000;
  localparam int unsigned PMC_INTERVAL_S    = 8;
  localparam int unsigned PMC_WINDOW_S      = 128;
  localparam int unsigned PMC_INTERVAL_CYC  = PMC_INTERVAL_S * PMC_CLK_HZ;
  localparam int unsigned PMC_HIST_ENTRIES  = PMC_WINDOW_S / PMC_INTERVAL_S;
  localparam logic [4:0]  PMC_HIST_LAST     = 5'(PMC_HIST_ENTRIES - 1);

  typedef enum logic [2:0] {
    PMC_ST_IDLE = 3'b001,
    PMC_ST_REC  = 3'b010,
    PMC_ST_DONE = 3'b100
  } pmc_hist_e;

endpackage : pmc_pkg

// ==== verilog/pmc_interval_timer.sv ====
`timescale 1ns/10ps
module pmc_interval_timer
  import pmc_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = PMC_INTERVAL_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  output logic      tick_out
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } pmc_timer_s;

  localparam logic [31:0] LAST = 32'(INTERVAL_CYCLES - 1);

  pmc_timer_s q;
  pmc_timer_s d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    // Stopped timer restarts from zero so each run has a full first interval
    if (!run_in) begin
      d.cnt = '0;
    end else if (q.cnt == LAST) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;

endmodule : pmc_interval_timer

// ==== verilog/pmc_mfr_regs.sv ====
// Notes on behaviour
// [R1] Sixteen status captures, every 8 s after ramp
// [R2] History reads as 32 bytes, entry 0 lowest
// [R3] Input offsets: on-trim high, off-trim low
// [R4] Output trim monitor reads as signed word
// [R5] Option bit 7 requires packet error checking
// [R6] Option bit 6 enables hybrid ratio regulation
// [R7] Option bit 5 selects non-linear droop
// [R8] Option bit 3 enables adaptive ramp, loop comp
// [R9] Option bit 2 enables dynamic bus voltage
// [R10] Option byte reads and writes whole; bits 0-1 inert
// [R11] Internal temperature offset word, 0.1 C steps
// [R12] Calibration block: offset low, slope high
// [R13] Bit 4 reserved; read-only writes rejected
`timescale 1ns/10ps
module pmc_mfr_regs
  import pmc_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = PMC_INTERVAL_CYC
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  input  wire logic         req_in,
  input  wire logic         req_write_in,
  input  wire logic [7:0]   req_code_in,
  input  wire logic [7:0]   req_wdata_in,
  input  wire logic         ramp_done_in,
  input  wire logic [15:0]  status_word_in,
  input  wire logic [15:0]  vin_offset_on_in,
  input  wire logic [15:0]  vin_offset_off_in,
  input  wire logic [15:0]  vout_trim_in,
  input  wire logic [15:0]  temp_offset_int_in,
  input  wire logic [15:0]  ext_cal_offset_in,
  input  wire logic [15:0]  ext_cal_slope_in,
  output logic              rsp_valid_out,
  output logic              rsp_error_out,
  output logic [5:0]        rsp_len_out,
  output logic [255:0]      rsp_data_out,
  output logic [7:0]        option_byte_out,
  output logic              pec_required_out,
  output logic              hybrid_ratio_regulation_out,
  output logic              droop_slope_select_out,
  output logic              adaptive_ramp_loop_comp_out,
  output logic              dynamic_bus_voltage_out,
  output logic              history_done_out
);

  typedef struct packed {
    pmc_hist_e          st;
    logic [4:0]         cnt;
    logic [15:0][15:0]  hist;
    logic [7:0]         opt;
    logic               rsp_valid;
    logic               rsp_err;
    logic [5:0]         rsp_len;
    logic [255:0]       rsp_data;
  } pmc_regs_s;

  localparam pmc_regs_s RESET_STATE = '{
    st:        PMC_ST_IDLE,
    cnt:       5'h00,
    hist:      '0,
    opt:       PMC_OPT_RESET,
    rsp_valid: 1'b0,
    rsp_err:   1'b0,
    rsp_len:   PMC_LEN_NONE,
    rsp_data:  '0
  };

  pmc_regs_s q;
  pmc_regs_s d;
  logic      tick;

  // Answer length per command; zero marks an unmapped code
  function automatic logic [5:0] cmd_len(input logic [7:0] code);
    case (code)
      PMC_CMD_INPUT_OFFSET_TRIMS:   cmd_len = PMC_LEN_BLK4;
      PMC_CMD_OUTPUT_TRIM_MONITOR:  cmd_len = PMC_LEN_WORD;
      PMC_CMD_STARTUP_STATUS_HIST:  cmd_len = PMC_LEN_BLK32;
      PMC_CMD_FEATURE_OPTION_BYTE:  cmd_len = PMC_LEN_BYTE;
      PMC_CMD_INTERNAL_TEMP_OFFSET: cmd_len = PMC_LEN_WORD;
      PMC_CMD_EXT_TEMP_CALIBRATION: cmd_len = PMC_LEN_BLK4;
      default:                      cmd_len = PMC_LEN_NONE;
    endcase
  endfunction : cmd_len

  pmc_interval_timer #(
    .INTERVAL_CYCLES (INTERVAL_CYCLES)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .run_in     (q.st == PMC_ST_REC),
    .tick_out   (tick)
  );

  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.rsp_err = 1'b0;

    // History recorder: one shot per power cycle, reset clears it
    case (q.st)
      PMC_ST_IDLE: begin
        if (ramp_done_in) begin
          d.st = PMC_ST_REC;
        end
      end
      PMC_ST_REC: begin
        if (tick) begin
          d.hist[q.cnt[3:0]] = status_word_in; // R1
          d.cnt = q.cnt + 5'h01; // R1
          if (q.cnt == PMC_HIST_LAST) begin
            d.st = PMC_ST_DONE; // R1
          end
        end
      end
      PMC_ST_DONE: begin
        d.st = PMC_ST_DONE;
      end
      default: begin
        d.st = PMC_ST_IDLE;
      end
    endcase

    if (req_in) begin
      d.rsp_valid = 1'b1;
      d.rsp_len = PMC_LEN_NONE;
      d.rsp_data = '0;
      if (req_write_in) begin
        if (req_code_in == PMC_CMD_FEATURE_OPTION_BYTE) begin
          // Reserved bits kept so the byte reads back as written
          d.opt = req_wdata_in; // R10
        end else begin
          d.rsp_err = 1'b1; // R13
        end
      end else begin
        d.rsp_len = cmd_len(req_code_in);
        d.rsp_err = (cmd_len(req_code_in) == PMC_LEN_NONE);
        case (req_code_in)
          PMC_CMD_INPUT_OFFSET_TRIMS: begin
            d.rsp_data[31:0] = {vin_offset_on_in, vin_offset_off_in}; // R3
          end
          PMC_CMD_OUTPUT_TRIM_MONITOR: begin
            d.rsp_data[15:0] = vout_trim_in; // R4
          end
          PMC_CMD_STARTUP_STATUS_HIST: begin
            d.rsp_data = q.hist; // R2
          end
          PMC_CMD_FEATURE_OPTION_BYTE: begin
            d.rsp_data[7:0] = q.opt; // R10
          end
          PMC_CMD_INTERNAL_TEMP_OFFSET: begin
            d.rsp_data[15:0] = temp_offset_int_in; // R11
          end
          PMC_CMD_EXT_TEMP_CALIBRATION: begin
            d.rsp_data[31:0] = {ext_cal_slope_in, ext_cal_offset_in}; // R12
          end
          default: begin
            d.rsp_data = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  assign rsp_valid_out = q.rsp_valid;
  assign rsp_error_out = q.rsp_err;
  assign rsp_len_out = q.rsp_len;
  assign rsp_data_out = q.rsp_data;
  assign option_byte_out = q.opt;
  assign pec_required_out = q.opt[PMC_OPT_PEC_BIT]; // R5
  assign hybrid_ratio_regulation_out = q.opt[PMC_OPT_HRR_BIT]; // R6
  assign droop_slope_select_out = q.opt[PMC_OPT_DROOP_BIT]; // R7
  assign adaptive_ramp_loop_comp_out = q.opt[PMC_OPT_ART_BIT]; // R8
  assign dynamic_bus_voltage_out = q.opt[PMC_OPT_DBV_BIT]; // R9
  assign history_done_out = (q.st == PMC_ST_DONE);

  sequence s_opt_wr;
    req_in && req_write_in && req_code_in == PMC_CMD_FEATURE_OPTION_BYTE;
  endsequence

  sequence s_rd(logic [7:0] code);
    req_in && !req_write_in && req_code_in == code;
  endsequence

  property p_capture;
    @(posedge clk_sys_in) disable iff (rst_in)
      (q.st == PMC_ST_REC && tick) |=>
        q.cnt == $past(q.cnt) + 5'h01 &&
        q.hist[$past(q.cnt[3:0])] == $past(status_word_in);
  endproperty
  a_capture: assert property (p_capture) // R1
    else $error("status capture missed on interval tick");

  property p_no_capture_outside;
    @(posedge clk_sys_in) disable iff (rst_in)
      q.st != PMC_ST_REC |=> $stable(q.cnt) && $stable(q.hist);
  endproperty
  a_no_capture_outside: assert property (p_no_capture_outside) // R1
    else $error("history changed outside the recording window");

  property p_hist_read;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_rd(PMC_CMD_STARTUP_STATUS_HIST) |=>
        rsp_valid_out && rsp_len_out == PMC_LEN_BLK32 &&
        rsp_data_out[15:0] == $past(q.hist[0]) &&
        rsp_data_out[255:240] == $past(q.hist[15]);
  endproperty
  a_hist_read: assert property (p_hist_read) // R2
    else $error("history block layout wrong");

  property p_vin_read;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_rd(PMC_CMD_INPUT_OFFSET_TRIMS) |=>
        rsp_len_out == PMC_LEN_BLK4 &&
        rsp_data_out[31:16] == $past(vin_offset_on_in) &&
        rsp_data_out[15:0] == $past(vin_offset_off_in);
  endproperty
  a_vin_read: assert property (p_vin_read) // R3
    else $error("input offset block wrong");

  property p_vout_read;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_rd(PMC_CMD_OUTPUT_TRIM_MONITOR) |=>
        rsp_len_out == PMC_LEN_WORD && !rsp_error_out &&
        rsp_data_out[15:0] == $past(vout_trim_in);
  endproperty
  a_vout_read: assert property (p_vout_read) // R4
    else $error("output trim word wrong");

  property p_pec_bit;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_opt_wr |=> pec_required_out == $past(req_wdata_in[7]);
  endproperty
  a_pec_bit: assert property (p_pec_bit) // R5
    else $error("packet check enable not taken from bit 7");

  property p_hrr_bit;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_opt_wr |=> hybrid_ratio_regulation_out == $past(req_wdata_in[6]);
  endproperty
  a_hrr_bit: assert property (p_hrr_bit) // R6
    else $error("hybrid ratio enable not taken from bit 6");

  property p_droop_bit;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_opt_wr |=> droop_slope_select_out == $past(req_wdata_in[5]);
  endproperty
  a_droop_bit: assert property (p_droop_bit) // R7
    else $error("droop select not taken from bit 5");

  property p_art_dbv_bits;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_opt_wr |=> adaptive_ramp_loop_comp_out == $past(req_wdata_in[3]) &&
        dynamic_bus_voltage_out == $past(req_wdata_in[2]);
  endproperty
  a_art_dbv_bits: assert property (p_art_dbv_bits) // R8
    else $error("ramp or bus voltage enable bit wrong");

  property p_opt_roundtrip;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_opt_wr ##1 s_rd(PMC_CMD_FEATURE_OPTION_BYTE) |=>
        rsp_len_out == PMC_LEN_BYTE &&
        rsp_data_out[7:0] == $past(req_wdata_in, 2);
  endproperty
  a_opt_roundtrip: assert property (p_opt_roundtrip) // R10
    else $error("option byte did not read back");

  property p_temp_read;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_rd(PMC_CMD_INTERNAL_TEMP_OFFSET) |=>
        rsp_len_out == PMC_LEN_WORD &&
        rsp_data_out[15:0] == $past(temp_offset_int_in);
  endproperty
  a_temp_read: assert property (p_temp_read) // R11
    else $error("internal temperature offset wrong");

  property p_cal_read;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_rd(PMC_CMD_EXT_TEMP_CALIBRATION) |=>
        rsp_len_out == PMC_LEN_BLK4 &&
        rsp_data_out[15:0] == $past(ext_cal_offset_in) &&
        rsp_data_out[31:16] == $past(ext_cal_slope_in);
  endproperty
  a_cal_read: assert property (p_cal_read) // R12
    else $error("calibration block wrong");

  property p_ro_write;
    @(posedge clk_sys_in) disable iff (rst_in)
      (req_in && req_write_in &&
       req_code_in != PMC_CMD_FEATURE_OPTION_BYTE) |=>
        rsp_valid_out && rsp_error_out && $stable(q.opt);
  endproperty
  a_ro_write: assert property (p_ro_write) // R13
    else $error("write to read-only command not rejected");

endmodule : pmc_mfr_regs

// ==== dv/pmc_host_model.sv ====
`timescale 1ns/10ps
module pmc_host_model (
  input  wire logic         clk_sys_in,
  input  wire logic         rsp_valid_in,
  input  wire logic         rsp_error_in,
  input  wire logic [5:0]   rsp_len_in,
  input  wire logic [255:0] rsp_data_in,
  output logic              req_out,
  output logic              req_write_out,
  output logic [7:0]        req_code_out,
  output logic [7:0]        req_wdata_out
);
  initial begin
    req_out       = 1'b0;
    req_write_out = 1'b0;
    req_code_out  = 8'h00;
    req_wdata_out = 8'h00;
  end

  // One-cycle request pulse; answer sampled after the edge that registers it
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [7:0] wd, output logic v,
                      output logic e, output logic [5:0] len,
                      output logic [255:0] d);
    @(posedge clk_sys_in);
    req_out       <= 1'b1;
    req_write_out <= wr;
    req_code_out  <= code;
    req_wdata_out <= wd;
    // Request taken here; the answer pulse stands for one cycle after it
    @(posedge clk_sys_in);
    req_out       <= 1'b0;
    // Qualifiers scrambled so a stale code cannot pass for a held one
    req_code_out  <= ~code;
    req_wdata_out <= ~wd;
    #1;
    v   = rsp_valid_in;
    e   = rsp_error_in;
    len = rsp_len_in;
    d   = rsp_data_in;
  endtask : xfer

  // Two requests on consecutive edges; answer of the second one returned
  task automatic xfer_pair(input logic wr0, input logic [7:0] code0,
                           input logic [7:0] wd0, input logic wr1,
                           input logic [7:0] code1, input logic [7:0] wd1,
                           output logic v, output logic e,
                           output logic [5:0] len, output logic [255:0] d);
    @(posedge clk_sys_in);
    req_out       <= 1'b1;
    req_write_out <= wr0;
    req_code_out  <= code0;
    req_wdata_out <= wd0;
    // Strobe held up so both requests land back to back
    @(posedge clk_sys_in);
    req_write_out <= wr1;
    req_code_out  <= code1;
    req_wdata_out <= wd1;
    @(posedge clk_sys_in);
    req_out       <= 1'b0;
    req_code_out  <= ~code1;
    req_wdata_out <= ~wd1;
    #1;
    v   = rsp_valid_in;
    e   = rsp_error_in;
    len = rsp_len_in;
    d   = rsp_data_in;
  endtask : xfer_pair
endmodule : pmc_host_model

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import pmc_pkg::*;
  localparam int unsigned IVL = 20;
  logic         clk_sys_in  = 1'b0;
  logic         rst_in      = 1'b1;
  logic         ramp_done   = 1'b0;
  logic [15:0]  status_word = 16'h0000;
  logic [15:0]  v_on        = 16'h0000;
  logic [15:0]  v_off       = 16'h0000;
  logic [15:0]  v_trim      = 16'h0000;
  logic [15:0]  t_off       = 16'h0000;
  logic [15:0]  c_off       = 16'h0000;
  logic [15:0]  c_slope     = 16'h0000;
  logic         req, req_wr, valid, err, hdone;
  logic         pec, hybrid_ratio_regulation, droop_slope_select, art, dynamic_bus_voltage;
  logic [7:0]   code, wd, opt;
  logic [5:0]   len;
  logic [255:0] data;
  int           failures = 0;
  int           compares = 0;
  int           cycles   = 0;

  pmc_mfr_regs #(.INTERVAL_CYCLES(IVL)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req),
    .req_write_in(req_wr), .req_code_in(code), .req_wdata_in(wd),
    .ramp_done_in(ramp_done), .status_word_in(status_word),
    .vin_offset_on_in(v_on), .vin_offset_off_in(v_off),
    .vout_trim_in(v_trim), .temp_offset_int_in(t_off),
    .ext_cal_offset_in(c_off), .ext_cal_slope_in(c_slope),
    .rsp_valid_out(valid), .rsp_error_out(err), .rsp_len_out(len),
    .rsp_data_out(data), .option_byte_out(opt), .pec_required_out(pec),
    .hybrid_ratio_regulation_out(hybrid_ratio_regulation), .droop_slope_select_out(droop_slope_select),
    .adaptive_ramp_loop_comp_out(art), .dynamic_bus_voltage_out(dynamic_bus_voltage),
    .history_done_out(hdone));

  pmc_host_model i_host (
    .clk_sys_in(clk_sys_in), .rsp_valid_in(valid), .rsp_error_in(err),
    .rsp_len_in(len), .rsp_data_in(data), .req_out(req),
    .req_write_out(req_wr), .req_code_out(code), .req_wdata_out(wd));

  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic stop_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // Generous ceiling: whole run is well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(string name, logic [255:0] exp, logic [255:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic op(logic wr, logic [7:0] c, logic [7:0] w, logic ee,
                    logic [5:0] el, logic [255:0] ed);
    logic         v, e;
    logic [5:0]   l;
    logic [255:0] d;
    i_host.xfer(wr, c, w, v, e, l, d);
    chk("rsp_valid", 256'(1'b1), 256'(v));
    chk("rsp_error", 256'(ee), 256'(e));
    chk("rsp_len", 256'(el), 256'(l));
    chk("rsp_data", ed, d);
  endtask : op

  task automatic t_reads();
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys_in);
      v_on    <= 16'h1234 ^ {16{p[0]}};
      v_off   <= 16'h5678 ^ {16{p[0]}};
      v_trim  <= 16'hfe0c ^ {16{p[0]}};
      t_off   <= 16'h00fa ^ {16{p[0]}};
      c_off   <= 16'h0110 ^ {16{p[0]}};
      c_slope <= 16'h2002 ^ {16{p[0]}};
      @(posedge clk_sys_in);
      op(1'b0, PMC_CMD_INPUT_OFFSET_TRIMS, 8'h00, 1'b0, PMC_LEN_BLK4,
         {224'h0, v_on, v_off});
      op(1'b0, PMC_CMD_OUTPUT_TRIM_MONITOR, 8'h00, 1'b0, PMC_LEN_WORD,
         {240'h0, v_trim});
      op(1'b0, PMC_CMD_INTERNAL_TEMP_OFFSET, 8'h00, 1'b0, PMC_LEN_WORD,
         {240'h0, t_off});
      op(1'b0, PMC_CMD_EXT_TEMP_CALIBRATION, 8'h00, 1'b0, PMC_LEN_BLK4,
         {224'h0, c_slope, c_off});
    end
  endtask : t_reads

  task automatic t_options();
    logic [7:0] pat [8] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h13,
                            8'hff, 8'h00};
    logic         v, e;
    logic [5:0]   l;
    logic [255:0] d;
    foreach (pat[i]) begin
      op(1'b1, PMC_CMD_FEATURE_OPTION_BYTE, pat[i], 1'b0, PMC_LEN_NONE,
         256'h0);
      chk("option_byte", 256'(pat[i]), 256'(opt));
      chk("pec", 256'(pat[i][7]), 256'(pec));
      chk("hrr", 256'(pat[i][6]), 256'(hybrid_ratio_regulation));
      chk("droop", 256'(pat[i][5]), 256'(droop_slope_select));
      chk("art", 256'(pat[i][3]), 256'(art));
      chk("dbv", 256'(pat[i][2]), 256'(dynamic_bus_voltage));
      op(1'b0, PMC_CMD_FEATURE_OPTION_BYTE, 8'h00, 1'b0, PMC_LEN_BYTE,
         {248'h0, pat[i]});
    end
    // Write then read on consecutive edges, back to back is legal
    i_host.xfer_pair(1'b1, PMC_CMD_FEATURE_OPTION_BYTE, 8'ha5, 1'b0,
                     PMC_CMD_FEATURE_OPTION_BYTE, 8'h00, v, e, l, d);
    chk("pair_valid", 256'(1'b1), 256'(v));
    chk("pair_error", 256'h0, 256'(e));
    chk("pair_len", 256'(PMC_LEN_BYTE), 256'(l));
    chk("pair_data", {248'h0, 8'ha5}, d);
  endtask : t_options

  task automatic t_refused();
    logic [7:0] ro [6] = '{8'hdd, 8'hde, 8'hdf, 8'he1, 8'he2, 8'hdc};
    foreach (ro[i]) begin
      op(1'b1, ro[i], 8'h5a, 1'b1, PMC_LEN_NONE, 256'h0);
    end
    op(1'b0, 8'he3, 8'h00, 1'b1, PMC_LEN_NONE, 256'h0);
    op(1'b0, PMC_CMD_FEATURE_OPTION_BYTE, 8'h00, 1'b0, PMC_LEN_BYTE,
       {248'h0, 8'ha5});
  endtask : t_refused

  task automatic t_history();
    logic [255:0] exp;
    int           n;
    exp = '0;
    @(posedge clk_sys_in);
    ramp_done <= 1'b1;
    // Word changes mid-interval so each capture sees a stable value
    for (int k = 0; k < 16; k++) begin
      repeat (IVL / 2) @(posedge clk_sys_in);
      status_word <= {12'hc00, 4'(k)};
      exp[16*k +: 16] = {12'hc00, 4'(k)};
      repeat (IVL / 2) @(posedge clk_sys_in);
    end
    #1;
    chk("history_done_early", 256'h0, 256'(hdone));
    n = 0;
    while (hdone !== 1'b1 && n < 2 * IVL) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    chk("history_done", 256'h1, 256'(hdone));
    op(1'b0, PMC_CMD_STARTUP_STATUS_HIST, 8'h00, 1'b0, PMC_LEN_BLK32,
       exp);
    status_word <= 16'h0bad;
    ramp_done   <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    ramp_done <= 1'b1;
    repeat (3 * IVL) @(posedge clk_sys_in);
    op(1'b0, PMC_CMD_STARTUP_STATUS_HIST, 8'h00, 1'b0, PMC_LEN_BLK32,
       exp);
  endtask : t_history

  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    chk("option_reset", 256'(PMC_OPT_RESET), 256'(opt));
    chk("history_reset", 256'h0, 256'(hdone));
    t_reads();
    t_options();
    t_refused();
    t_history();
    stop_test();
  end
endmodule : testbench
